/* File: core/tss_pkg.sv */
// Types shared by the splicer
package tss_pkg;
  typedef logic [7:0] tss_byte_t;
  typedef logic [12:0] tss_pid_t;
  typedef enum logic [1:0] {md_pass, md_armed, md_insert} tss_mode_e;
  typedef enum logic [1:0] {ph_hdr, ph_emit, ph_body} tss_phase_e;
endpackage : tss_pkg

/* File: core/tss_regs.svh */
// Register offsets, field positions, reset values and packet layout of the splicer
`ifndef TSS_REGS_SVH
`define TSS_REGS_SVH
`define TSS_CTRL 8'h00
`define TSS_STAT 8'h04
`define TSS_PID0 8'h08
`define TSS_PID3 8'h14
`define TSS_PMT 8'h18
`define TSS_CDN 8'h1C
`define TSS_SEG 8'h20
`define TSS_PCR 8'h24
`define TSS_CTRL_ARM 0
`define TSS_CTRL_PAUSE 1
`define TSS_ENT_VALID 13
`define TSS_ENT_VIDEO 14
`define TSS_ENT_DROP 15
`define TSS_CDN_RST 8'h08
`define TSS_SEG_RST 16'h0010
`define TSS_PMT_RST 13'h0020
`define TSS_LAST_IDX 8'hBB
`define TSS_SYNC 8'h47
`define TSS_PUSI_BIT 6
`define TSS_AF_BIT 5
`define TSS_DISC_BIT 7
`define TSS_PCRF_BIT 4
`define TSS_OPCRF_BIT 3
`define TSS_SPLF_BIT 2
`define TSS_ALIGN_BIT 2
`define TSS_PTS_BIT 7
`define TSS_START_CODE 24'h000001
`define TSS_SEQ_CODE 32'h000001B3
`define TSS_FIFO_DEPTH 13'h1000
`endif

/* File: core/tss_splicer.sv */
// Transport stream splicer: PID demux, packet-wise insertion, splice signalling
`timescale 1ns/1ps
`default_nettype none
`include "tss_regs.svh"

module tss_splicer (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Network or local feed
  input wire tss_pkg::tss_byte_t main_data,
  input wire logic main_valid,
  output logic main_ready,
  // Inserted segment source
  input wire tss_pkg::tss_byte_t ins_data,
  input wire logic ins_valid,
  output logic ins_ready,
  // Output to the decoder
  output tss_pkg::tss_byte_t out_data,
  output logic out_sop,
  output logic out_valid,
  input wire logic out_ready,
  // Status
  output logic splice_active
);
  import tss_pkg::*;

  // ****************************************
  // Declarations
  // ****************************************
  logic pause_reg;
  logic [15:0] pid_reg [0:3];
  tss_pid_t pmt_reg;
  logic [7:0] cdn_reg;
  logic [15:0] seg_reg;
  logic [31:0] pcr_reg;
  logic [4:0] err_reg;
  logic [4:0] err_set;
  logic [31:0] rdata_reg;
  tss_mode_e mode_reg;
  tss_phase_e ph_reg;
  logic [7:0] idx_reg;
  logic [1:0] ecnt_reg;
  tss_byte_t hdr_reg [0:3];
  logic sel_reg;
  logic drop_reg;
  logic vid_reg;
  logic pusi_reg;
  logic af_reg;
  logic [7:0] aflen_reg;
  logic pcrf_reg;
  logic opcrf_reg;
  logic splf_reg;
  logic [7:0] hlen_reg;
  logic [23:0] shift_reg;
  logic [7:0] cnt_reg;
  logic [15:0] segcnt_reg;
  logic first_reg;
  logic ret_disc_reg;
  tss_byte_t mem [0:4095];
  logic [12:0] wr_ptr_reg;
  logic [12:0] rd_ptr_reg;
  logic [8:0] buf0_reg;
  logic [8:0] buf1_reg;
  logic [1:0] bcnt_reg;
  logic arm;
  logic clr_hit;
  logic sel_now;
  logic src_valid;
  tss_byte_t src_data;
  logic take;
  logic buf_in_ready;
  logic push;
  logic [8:0] push_data;
  logic pop;
  logic fifo_full;
  logic fifo_empty;
  logic pkt_end;
  tss_pid_t pid;
  logic prog_hit;
  logic vid_hit;
  logic rm_hit;
  logic is_pmt;
  logic drop_now;
  tss_byte_t mod_byte;
  logic [8:0] rel;
  logic [8:0] spl_pos;

  // ****************************************
  // Register port
  // ****************************************
  assign arm = reg_wr && (reg_addr == `TSS_CTRL) && reg_wdata[`TSS_CTRL_ARM];
  assign clr_hit = reg_wr && (reg_addr == `TSS_STAT);

  // Software-written configuration
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      pause_reg <= 1'b0;
      pmt_reg <= `TSS_PMT_RST;
      cdn_reg <= `TSS_CDN_RST;
      seg_reg <= `TSS_SEG_RST;
      for (int i = 0; i < 4; i++)
        pid_reg[i] <= 16'h0000;
    end
    else if (reg_wr)
    begin
      if (reg_addr == `TSS_CTRL)
        pause_reg <= reg_wdata[`TSS_CTRL_PAUSE];
      else if (reg_addr == `TSS_PMT)
        pmt_reg <= reg_wdata[12:0];
      else if (reg_addr == `TSS_CDN)
        cdn_reg <= reg_wdata[7:0];
      else if (reg_addr == `TSS_SEG)
        seg_reg <= reg_wdata[15:0];
      else if (reg_addr >= `TSS_PID0 && reg_addr <= `TSS_PID3 && reg_addr[1:0] == 2'b00)
        pid_reg[reg_addr[3:2] + 2'h2] <= reg_wdata[15:0];
    end
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge clock)
  begin
    if (rst)
      rdata_reg <= 32'h00000000;
    else if (!reg_rd)
      rdata_reg <= 32'h00000000;
    else if (reg_addr == `TSS_CTRL)
      rdata_reg <= {30'h00000000, pause_reg, 1'b0};
    else if (reg_addr == `TSS_STAT)
      rdata_reg <= {3'h0, wr_ptr_reg - rd_ptr_reg, 3'h0, err_reg, 6'h00, mode_reg};
    else if (reg_addr >= `TSS_PID0 && reg_addr <= `TSS_PID3 && reg_addr[1:0] == 2'b00)
      rdata_reg <= {16'h0000, pid_reg[reg_addr[3:2] + 2'h2]};
    else if (reg_addr == `TSS_PMT)
      rdata_reg <= {19'h00000, pmt_reg};
    else if (reg_addr == `TSS_CDN)
      rdata_reg <= {24'h000000, cdn_reg};
    else if (reg_addr == `TSS_SEG)
      rdata_reg <= {16'h0000, seg_reg};
    else if (reg_addr == `TSS_PCR)
      rdata_reg <= pcr_reg;
    else
      rdata_reg <= 32'h00000000;
  end
  assign reg_rdata = rdata_reg;

  // Sticky error flags, write one to clear, a new error wins
  always_ff @(posedge clock)
  begin
    if (rst)
      err_reg <= 5'h00;
    else
      err_reg <= (err_reg & ~(clr_hit ? reg_wdata[12:8] : 5'h00)) | err_set;
  end

  // ****************************************
  // Feed buffer
  // ****************************************
  assign fifo_full = (wr_ptr_reg - rd_ptr_reg) == `TSS_FIFO_DEPTH;
  assign fifo_empty = wr_ptr_reg == rd_ptr_reg;
  assign main_ready = !fifo_full && !(pause_reg && mode_reg == md_insert);

  // Circular byte store for the network feed
  always_ff @(posedge clock)
  begin
    if (main_valid && main_ready)
      mem[wr_ptr_reg[11:0]] <= main_data;
  end

  // Feed pointers
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      wr_ptr_reg <= 13'h0000;
      rd_ptr_reg <= 13'h0000;
    end
    else
    begin
      if (main_valid && main_ready)
        wr_ptr_reg <= wr_ptr_reg + 13'h0001;
      if (take && !sel_now)
        rd_ptr_reg <= rd_ptr_reg + 13'h0001;
    end
  end

  // ****************************************
  // Packet decode
  // ****************************************
  // source fixed per packet
  assign sel_now = (ph_reg == ph_hdr && idx_reg == 8'h00) ? (mode_reg == md_insert) : sel_reg;
  assign src_valid = sel_now ? ins_valid : !fifo_empty;
  assign src_data = sel_now ? ins_data : mem[rd_ptr_reg[11:0]];
  assign take = src_valid && (ph_reg == ph_hdr || (ph_reg == ph_body && (drop_reg || buf_in_ready)));
  assign ins_ready = sel_now && (ph_reg == ph_hdr || (ph_reg == ph_body && (drop_reg || buf_in_ready)));
  assign pkt_end = take && ph_reg == ph_body && idx_reg == `TSS_LAST_IDX;
  assign splice_active = mode_reg == md_insert;

  always_comb
  begin
    pid = {hdr_reg[1][4:0], hdr_reg[2]};
    prog_hit = 1'b0;
    vid_hit = 1'b0;
    rm_hit = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      if (pid_reg[i][`TSS_ENT_VALID] && pid_reg[i][12:0] == pid)
      begin
        prog_hit = 1'b1;
        vid_hit = vid_hit | pid_reg[i][`TSS_ENT_VIDEO];
        rm_hit = rm_hit | pid_reg[i][`TSS_ENT_DROP];
      end
    end
    is_pmt = pid == pmt_reg;
  end

  assign drop_now = (hdr_reg[0] != `TSS_SYNC) || (!sel_reg && rm_hit) || (sel_reg && !prog_hit && !is_pmt);

  // Byte rewrite and positions inside the current packet
  always_comb
  begin
    mod_byte = src_data;
    rel = {1'b0, idx_reg} - (af_reg ? 9'h005 + {1'b0, aflen_reg} : 9'h004);
    spl_pos = 9'h006 + (pcrf_reg ? 9'h006 : 9'h000) + (opcrf_reg ? 9'h006 : 9'h000);
    if (af_reg && idx_reg == 8'h05 && vid_reg)
    begin
      if (sel_reg && first_reg)
        mod_byte[`TSS_DISC_BIT] = 1'b1;
      if (!sel_reg && ret_disc_reg && src_data[`TSS_PCRF_BIT])
        mod_byte[`TSS_DISC_BIT] = 1'b1;
    end
    if (af_reg && splf_reg && idx_reg > 8'h05 && {1'b0, idx_reg} == spl_pos && !sel_reg && vid_reg
        && mode_reg == md_armed)
      mod_byte = cnt_reg;
  end

  // ****************************************
  // Packet sequencer
  // ****************************************
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      ph_reg <= ph_hdr;
      idx_reg <= 8'h00;
      ecnt_reg <= 2'h0;
      sel_reg <= 1'b0;
      drop_reg <= 1'b0;
      vid_reg <= 1'b0;
      pusi_reg <= 1'b0;
      af_reg <= 1'b0;
      for (int i = 0; i < 4; i++)
        hdr_reg[i] <= 8'h00;
    end
    else
    begin
      case (ph_reg)
        ph_hdr:
        begin
          if (take)
          begin
            hdr_reg[idx_reg[1:0]] <= src_data;
            idx_reg <= idx_reg + 8'h01;
            if (idx_reg == 8'h00)
              sel_reg <= sel_now;
            if (idx_reg == 8'h03)
              ph_reg <= ph_decide_next();
          end
        end
        ph_emit:
        begin
          if (drop_now)
            ph_reg <= ph_body;
          else if (buf_in_ready)
          begin
            ecnt_reg <= ecnt_reg + 2'h1;
            if (ecnt_reg == 2'h3)
              ph_reg <= ph_body;
          end
        end
        default:
        begin
          if (take)
            idx_reg <= idx_reg + 8'h01;
          if (pkt_end)
          begin
            idx_reg <= 8'h00;
            ph_reg <= ph_hdr;
          end
        end
      endcase
      // Latch header decisions once the fourth byte is known
      if (ph_reg == ph_emit && ecnt_reg == 2'h0 || ph_reg == ph_hdr && idx_reg == 8'h04)
      begin
        drop_reg <= drop_now;
        vid_reg <= vid_hit;
        pusi_reg <= hdr_reg[1][`TSS_PUSI_BIT];
        af_reg <= hdr_reg[3][`TSS_AF_BIT];
      end
    end
  end

  // Next phase after the header: always the emit phase, which a dropped packet leaves without emitting its header
  function automatic tss_phase_e ph_decide_next();
    ph_decide_next = ph_emit;
  endfunction : ph_decide_next

  // Adaptation field and PES header fields of the packet in flight
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      aflen_reg <= 8'h00;
      pcrf_reg <= 1'b0;
      opcrf_reg <= 1'b0;
      splf_reg <= 1'b0;
      hlen_reg <= 8'h00;
      shift_reg <= 24'h000000;
    end
    else if (take && ph_reg == ph_body)
    begin
      shift_reg <= {shift_reg[15:0], src_data};
      if (idx_reg == 8'h04)
        aflen_reg <= src_data;
      if (idx_reg == 8'h05)
      begin
        pcrf_reg <= src_data[`TSS_PCRF_BIT];
        opcrf_reg <= src_data[`TSS_OPCRF_BIT];
        splf_reg <= src_data[`TSS_SPLF_BIT];
      end
      if (rel == 9'h008)
        hlen_reg <= src_data;
    end
  end

  // ****************************************
  // Insertion checks and PCR capture
  // ****************************************
  always_comb
  begin
    err_set = 5'h00;
    // Lost sync byte
    if (ph_reg == ph_emit && ecnt_reg == 2'h0 && hdr_reg[0] != `TSS_SYNC)
      err_set[0] = 1'b1;
    if (take && ph_reg == ph_body && sel_reg && vid_reg && !drop_reg)
    begin
      if (first_reg && idx_reg == 8'h04 && !af_reg)
        err_set[1] = 1'b1;
      if (first_reg && af_reg && idx_reg == 8'h05 && !src_data[`TSS_PCRF_BIT])
        err_set[1] = 1'b1;
      if (first_reg && (!pusi_reg && idx_reg == 8'h04 || pusi_reg && rel == 9'h007 && !src_data[`TSS_PTS_BIT]))
        err_set[2] = 1'b1;
      if (first_reg && pusi_reg && rel == 9'h006 && !src_data[`TSS_ALIGN_BIT])
        err_set[3] = 1'b1;
      if (pusi_reg && rel == 9'h00B + {1'b0, hlen_reg} && {shift_reg[15:0], src_data} != `TSS_START_CODE)
        err_set[4] = 1'b1;
      if (first_reg && pusi_reg && rel == 9'h00C + {1'b0, hlen_reg} && {shift_reg, src_data} != `TSS_SEQ_CODE)
        err_set[4] = 1'b1;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      pcr_reg <= 32'h00000000;
    else if (take && ph_reg == ph_body && sel_reg && vid_reg && first_reg && pcrf_reg && af_reg
             && idx_reg >= 8'h06 && idx_reg <= 8'h09)
      pcr_reg <= {pcr_reg[23:0], src_data};
  end

  // ****************************************
  // Splice mode control
  // ****************************************
  // one source per program
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      mode_reg <= md_pass;
      cnt_reg <= 8'h00;
      segcnt_reg <= 16'h0000;
      first_reg <= 1'b0;
      ret_disc_reg <= 1'b0;
    end
    else
    begin
      case (mode_reg)
        md_pass:
        begin
          if (arm && cdn_reg != 8'h00)
          begin
            mode_reg <= md_armed;
            cnt_reg <= cdn_reg;
          end
          if (pkt_end && !sel_reg && vid_reg && af_reg && pcrf_reg)
            ret_disc_reg <= 1'b0;
        end
        md_armed:
        begin
          if (pkt_end && !sel_reg && vid_reg)
          begin
            if (cnt_reg == 8'h00)
            begin
              mode_reg <= md_insert;
              segcnt_reg <= 16'h0000;
              first_reg <= 1'b1;
            end
            else
              cnt_reg <= cnt_reg - 8'h01;
          end
        end
        default:
        begin
          if (pkt_end && sel_reg && !drop_reg)
          begin
            segcnt_reg <= segcnt_reg + 16'h0001;
            if (vid_reg)
              first_reg <= 1'b0;
            if (segcnt_reg + 16'h0001 >= seg_reg)
            begin
              mode_reg <= md_pass;
              ret_disc_reg <= 1'b1;
            end
          end
        end
      endcase
    end
  end

  // ****************************************
  // Output buffer, two entries
  // ****************************************
  assign buf_in_ready = bcnt_reg != 2'h2;
  assign push = (ph_reg == ph_emit && buf_in_ready && !drop_now) || (ph_reg == ph_body && take && !drop_reg);
  assign push_data = (ph_reg == ph_emit) ? {ecnt_reg == 2'h0, hdr_reg[ecnt_reg]} : {1'b0, mod_byte};
  assign pop = out_valid && out_ready;

  // Entry shift and count
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      buf0_reg <= 9'h000;
      buf1_reg <= 9'h000;
      bcnt_reg <= 2'h0;
    end
    else if (push && !pop)
    begin
      if (bcnt_reg == 2'h0)
        buf0_reg <= push_data;
      else
        buf1_reg <= push_data;
      bcnt_reg <= bcnt_reg + 2'h1;
    end
    else if (pop && !push)
    begin
      buf0_reg <= buf1_reg;
      bcnt_reg <= bcnt_reg - 2'h1;
    end
    else if (pop && push)
    begin
      buf0_reg <= push_data;
    end
  end

  assign out_valid = bcnt_reg != 2'h0;
  assign out_data = buf0_reg[7:0];
  assign out_sop = buf0_reg[8];
endmodule : tss_splicer
`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench for the splicer
`timescale 1ns/1ps
`default_nettype none
`include "tss_regs.svh"
module testbench;
  import tss_pkg::*;
  localparam logic [191:0] INS_HDR = 192'h12345678_0000_000001E0_0000_848005_2100010001_000001B3;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  tss_byte_t sdata = 8'h00;
  logic svalid = 1'b0;
  logic ssel = 1'b0;
  logic main_ready;
  logic ins_ready;
  tss_byte_t out_data;
  logic out_valid;
  logic out_ready;
  logic splice_active;
  logic hold = 1'b0;
  logic slow = 1'b1;
  logic [15:0] pkt_count;
  tss_byte_t pk [188];
  int fail_count = 0;
  int n_checks = 0;
  int npk = 0;
  wire logic srdy = ssel ? ins_ready : main_ready;
  tss_splicer dut (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .main_data(sdata), .main_valid(svalid && !ssel),
    .main_ready(main_ready), .ins_data(sdata), .ins_valid(svalid && ssel), .ins_ready(ins_ready),
    .out_data(out_data), .out_sop(), .out_valid(out_valid), .out_ready(out_ready),
    .splice_active(splice_active));
  tss_decoder_model sink (.clock(clock), .rst(rst), .out_data(out_data), .out_valid(out_valid),
    .out_ready(out_ready), .hold(hold), .slow(slow), .pkt_count(pkt_count));
  // 100 ns clock
  initial
  begin
    forever #50 clock = ~clock;
  end
  // ****************************************
  // Shared tasks
  // ****************************************
  task chk8(input string what, input tss_byte_t exp, input tss_byte_t got);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk8
  task chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk32
  task wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
  endtask : wr
  // Read a register and compare the masked word
  task rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string what);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    chk32(what, e, reg_rdata & m);
    @(posedge clock);
  endtask : rdchk
  // Build a packet: header, optional adaptation field, pattern payload
  task mk(input tss_pid_t pid, input logic pusi, input tss_byte_t flg, input tss_byte_t alen);
    int i;
    for (i = 0; i < 188; i++)
      pk[i] = i[7:0] ^ 8'h5A;
    pk[0] = `TSS_SYNC;
    pk[1] = {1'b0, pusi, 1'b0, pid[12:8]};
    pk[2] = pid[7:0];
    pk[3] = (alen != 8'h00) ? 8'h30 : 8'h10;
    pk[4] = alen;
    pk[5] = flg;
  endtask : mk
  // Send a whole packet to the feed (0) or insert side (1)
  task sendp(input logic sel);
    int i;
    int k;
    logic r;
    ssel <= sel;
    for (i = 0; i < 188; i++)
    begin
      sdata <= pk[i];
      svalid <= 1'b1;
      k = 0;
      do
      begin
        @(negedge clock);
        r = srdy;
        @(posedge clock);
        k++;
      end
      while (r !== 1'b1 && k < 9000);
      if (r !== 1'b1) chk8("source ready", 8'h01, {7'h0, r});
    end
    svalid <= 1'b0;
    @(posedge clock);
  endtask : sendp
  // Wait for the next packet at the decoder
  task await;
    int k;
    npk++;
    k = 0;
    while (pkt_count !== npk[15:0] && k < 9000)
    begin
      @(posedge clock);
      k++;
    end
    chk32("packets out", npk, {16'h0, pkt_count});
  endtask : await
  task cmp_pkt(input int ix, input tss_byte_t v);
    int i;
    for (i = 0; i < 188; i++)
      chk8("out byte", (i == ix) ? v : pk[i], sink.last_pkt[i]);
  endtask : cmp_pkt
  // Feed video packets carrying the countdown, n down to zero
  task count_in(input int n);
    int c;
    for (c = n; c >= 0; c--)
    begin
      mk(13'h100, 1'b0, 8'h04, 8'h02);
      sendp(1'b0);
      await;
      cmp_pkt(6, c[7:0]);
    end
  endtask : count_in
  // ****************************************
  // Scenarios
  // ****************************************
  task t_reset;
    rdchk(`TSS_STAT, 32'hFFFFFFFF, 32'h0, "status");
    rdchk(`TSS_CDN, 32'hFF, {24'h0, `TSS_CDN_RST}, "countdown");
    rdchk(`TSS_SEG, 32'hFFFF, {16'h0, `TSS_SEG_RST}, "segment");
    rdchk(`TSS_PMT, 32'h1FFF, {19'h0, `TSS_PMT_RST}, "pmt pid");
    wr(8'h30, 32'hFFFFFFFF);
    rdchk(8'h30, 32'hFFFFFFFF, 32'h0, "unmapped");
    chk8("feed ready", 8'h01, {7'h0, main_ready});
  endtask : t_reset
  task t_pass;
    wr(`TSS_PID0, 32'h6100);
    wr(`TSS_PID0 + 8'h04, 32'hA200);
    mk(13'h200, 1'b0, 8'h00, 8'h00);
    sendp(1'b0);
    mk(13'h100, 1'b0, 8'h00, 8'h00);
    sendp(1'b0);
    await;
    cmp_pkt(0, pk[0]);
  endtask : t_pass
  task t_splice;
    int j;
    wr(`TSS_CDN, 32'h2);
    wr(`TSS_SEG, 32'h1);
    wr(`TSS_CTRL, 32'h1);
    rdchk(`TSS_STAT, 32'h3, 32'h1, "mode armed");
    count_in(2);
    rdchk(`TSS_STAT, 32'h3, 32'h2, "mode insert");
    chk8("splice active", 8'h01, {7'h0, splice_active});
    mk(13'h100, 1'b1, 8'h10, 8'h07);
    for (j = 0; j < 24; j++)
      pk[6 + j] = INS_HDR[191 - 8 * j -: 8];
    sendp(1'b1);
    await;
    cmp_pkt(5, 8'h90);
    rdchk(`TSS_STAT, 32'h1FFF1FFF, 32'h0, "status after segment");
    rdchk(`TSS_PCR, 32'hFFFFFFFF, 32'h12345678, "pcr");
    mk(13'h100, 1'b0, 8'h10, 8'h07);
    sendp(1'b0);
    await;
    cmp_pkt(5, 8'h90);
  endtask : t_splice
  task t_pause;
    wr(`TSS_CDN, 32'h1);
    wr(`TSS_CTRL, 32'h3);
    rdchk(`TSS_CTRL, 32'hFFFFFFFF, 32'h2, "control");
    count_in(1);
    chk8("feed halted", 8'h00, {7'h0, main_ready});
    mk(13'h155, 1'b0, 8'h00, 8'h00);
    sendp(1'b1);
    mk(13'h100, 1'b0, 8'h10, 8'h07);
    sendp(1'b1);
    await;
    rdchk(`TSS_STAT, 32'h0403, 32'h0400, "missing pes");
    wr(`TSS_STAT, 32'h1F00);
    rdchk(`TSS_STAT, 32'h1F03, 32'h0, "errors cleared");
    wr(`TSS_CTRL, 32'h0);
  endtask : t_pause
  task t_buffer;
    int k;
    hold <= 1'b1;
    fork
      repeat (23)
      begin
        mk(13'h300, 1'b0, 8'h00, 8'h00);
        sendp(1'b0);
      end
    join_none
    k = 0;
    while ((main_ready !== 1'b0 || !svalid) && k < 9000)
    begin
      @(posedge clock);
      k++;
    end
    rdchk(`TSS_STAT, 32'h1FFF0000, {3'h0, `TSS_FIFO_DEPTH, 16'h0}, "buffer full");
    hold <= 1'b0;
    wait fork;
    npk = npk + 22;
    await;
    cmp_pkt(0, pk[0]);
    rdchk(`TSS_STAT, 32'h1FFF0000, 32'h0, "buffer empty");
  endtask : t_buffer
  task final_report;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : final_report
  // Main sequence
  initial
  begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    t_reset;
    t_pass;
    t_splice;
    t_pause;
    t_buffer;
    final_report;
  end
  // Watchdog against a hang
  initial
  begin
    #4000000;
    fail_count++;
    $display("BAD watchdog expected finish seen hang");
    final_report;
  end
endmodule : testbench
`default_nettype wire

/* File: tb/tss_decoder_model.sv */
// Decoder-side model: takes output packets and stalls on demand
`timescale 1ns/1ps
`default_nettype none
module tss_decoder_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Stream from the splicer
  input wire tss_pkg::tss_byte_t out_data,
  input wire logic out_valid,
  output logic out_ready,
  // Stall controls and packet count
  input wire logic hold,
  input wire logic slow,
  output logic [15:0] pkt_count
);
  import tss_pkg::*;
  tss_byte_t cur_mem [188];
  tss_byte_t last_pkt [188];
  logic [7:0] pos_reg;
  logic [1:0] cyc_reg;
  // Ready withheld on hold, and one cycle in four when slow
  assign out_ready = !hold && !(slow && cyc_reg == 2'h0);
  always_ff @(posedge clock)
  begin
    cyc_reg <= rst ? 2'h0 : cyc_reg + 2'h1;
    if (rst)
    begin
      pos_reg <= 8'h00;
      pkt_count <= 16'h0000;
    end
    else if (out_valid && out_ready)
    begin
      cur_mem[pos_reg] <= out_data;
      pos_reg <= (pos_reg == 8'hBB) ? 8'h00 : pos_reg + 8'h01;
      if (pos_reg == 8'hBB)
      begin
        for (int i = 0; i < 187; i++)
          last_pkt[i] <= cur_mem[i];
        last_pkt[187] <= out_data;
        pkt_count <= pkt_count + 16'h0001;
      end
    end
  end
endmodule : tss_decoder_model
`default_nettype wire

/* File: tb/tss_splicer_chk.sv */
// Port-level assertions for the splicer, bound into its top module
`timescale 1ns/1ps
`default_nettype none
`include "tss_regs.svh"
module tss_splicer_chk (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Streams and status
  input wire logic main_valid,
  input wire logic main_ready,
  input wire logic ins_valid,
  input wire logic ins_ready,
  input wire tss_pkg::tss_byte_t out_data,
  input wire logic out_sop,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire logic splice_active
);
  import tss_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  logic [7:0] opos_reg;
  logic [7:0] fpos_reg;
  logic [7:0] ipos_reg;
  logic pause_reg;
  logic arm_reg;
  // ****************************************
  // Helper state
  // ****************************************
  // Byte position within output, feed and insert packets
  always_ff @(posedge clock)
    if (rst || (out_valid && out_ready && opos_reg == `TSS_LAST_IDX)) opos_reg <= 8'h00;
    else if (out_valid && out_ready) opos_reg <= opos_reg + 8'h01;
  always_ff @(posedge clock)
    if (rst || (main_valid && main_ready && fpos_reg == `TSS_LAST_IDX)) fpos_reg <= 8'h00;
    else if (main_valid && main_ready) fpos_reg <= fpos_reg + 8'h01;
  always_ff @(posedge clock)
    if (rst || (ins_valid && ins_ready && ipos_reg == `TSS_LAST_IDX)) ipos_reg <= 8'h00;
    else if (ins_valid && ins_ready) ipos_reg <= ipos_reg + 8'h01;
  // Pause setting and arm history from control writes
  always_ff @(posedge clock)
    if (rst) pause_reg <= 1'b0;
    else if (reg_wr && reg_addr == `TSS_CTRL) pause_reg <= reg_wdata[`TSS_CTRL_PAUSE];
  always_ff @(posedge clock)
    if (rst) arm_reg <= 1'b0;
    else if (reg_wr && reg_addr == `TSS_CTRL && reg_wdata[`TSS_CTRL_ARM]) arm_reg <= 1'b1;
  // ****************************************
  // Assertions
  // ****************************************
  property p_sop_sync; out_valid && out_sop |-> out_data == `TSS_SYNC; endproperty
  a_sop_sync: assert property (p_sop_sync) else $error("packet start without sync byte");
  property p_hold; out_valid && !out_ready |=> out_valid && $stable(out_data) && $stable(out_sop); endproperty
  a_hold: assert property (p_hold) else $error("output changed while stalled");
  property p_sop_pos; out_valid |-> (out_sop == (opos_reg == 8'h00)); endproperty
  a_sop_pos: assert property (p_sop_pos) else $error("packet start off a 188 byte boundary");
  property p_rd_idle; !reg_rd |=> reg_rdata == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data without a read strobe");
  property p_pause; pause_reg && splice_active |-> !main_ready; endproperty
  a_pause: assert property (p_pause) else $error("feed taken while paused insertion");
  property p_arm; $rose(splice_active) |-> arm_reg; endproperty
  a_arm: assert property (p_arm) else $error("insertion without arming");
  property p_switch; $rose(splice_active) |-> fpos_reg == 8'h00; endproperty
  a_switch: assert property (p_switch) else $error("switch inside a feed packet");
  property p_return; $fell(splice_active) |-> ipos_reg == 8'h00; endproperty
  a_return: assert property (p_return) else $error("return inside an inserted packet");
  property p_one_src; ins_ready |-> splice_active; endproperty
  a_one_src: assert property (p_one_src) else $error("insert side open outside insertion");
  // Main scenarios reached
  c_insert: cover property ($rose(splice_active));
  c_return: cover property ($fell(splice_active));
  c_stall: cover property (out_valid && !out_ready);
  c_full: cover property (main_valid && !main_ready);
endmodule : tss_splicer_chk
bind tss_splicer tss_splicer_chk u_chk (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .main_valid(main_valid), .main_ready(main_ready),
  .ins_valid(ins_valid), .ins_ready(ins_ready), .out_data(out_data), .out_sop(out_sop),
  .out_valid(out_valid), .out_ready(out_ready), .splice_active(splice_active));
`default_nettype wire
